/* ckev_pkg.sv */
// constants shared by the clock event register block and its helpers
// assumes a single 100 MHz system clock and a plain register port
package ckev_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam int CKEV_AW = 12;
  localparam int CKEV_DW = 32;
  localparam int CKEV_NEV = 6;
  localparam logic [11:0] CKEV_OFF_CT_START = 12'h014;
  localparam logic [11:0] CKEV_OFF_CT_STOP = 12'h018;
  localparam logic [11:0] CKEV_OFF_EV_HF = 12'h100;
  localparam logic [11:0] CKEV_OFF_EV_LF = 12'h104;
  localparam logic [11:0] CKEV_OFF_EV_DONE = 12'h10c;
  localparam logic [11:0] CKEV_OFF_EV_TMO = 12'h110;
  localparam logic [11:0] CKEV_OFF_EV_CTSTART = 12'h128;
  localparam logic [11:0] CKEV_OFF_EV_CTSTOP = 12'h12c;
  localparam logic [11:0] CKEV_OFF_INT_SET = 12'h304;
  localparam logic [11:0] CKEV_OFF_INT_CLR = 12'h308;

  // ==========================================================
  // event bit positions, shared by event flags and enable bits, and the task trigger bit
  localparam int CKEV_BIT_HF = 0;
  localparam int CKEV_BIT_LF = 1;
  localparam int CKEV_BIT_DONE = 2;
  localparam int CKEV_BIT_TMO = 3;
  localparam int CKEV_BIT_CTSTART = 4;
  localparam int CKEV_BIT_CTSTOP = 5;
  localparam int CKEV_BIT_TRIG = 0;

  localparam logic [11:0] CKEV_EV_OFF [0:5] = '{
    CKEV_OFF_EV_HF, CKEV_OFF_EV_LF, CKEV_OFF_EV_DONE,
    CKEV_OFF_EV_TMO, CKEV_OFF_EV_CTSTART, CKEV_OFF_EV_CTSTOP
  };

  // ==========================================================
  // reset values
  localparam logic [31:0] CKEV_RST_WORD = 32'h0000_0000;
  localparam logic [5:0] CKEV_RST_INT_EN = 6'h00;
  localparam logic CKEV_RST_FLAG = 1'b0;

  // ==========================================================
  // timing
  localparam int CKEV_CLK_NS = 10;
  localparam int CKEV_CT_START_NS = 20;
  localparam int CKEV_CT_START_CYC =
    ((CKEV_CT_START_NS + CKEV_CLK_NS - 1) / CKEV_CLK_NS < 1) ? 1 :
    (CKEV_CT_START_NS + CKEV_CLK_NS - 1) / CKEV_CLK_NS;
  localparam int CKEV_CT_PERIOD_US = 40;
  localparam int CKEV_CT_PERIOD_CYC = (CKEV_CT_PERIOD_US * 1000) / CKEV_CLK_NS;
  localparam int CKEV_CTW = 12;

  typedef enum logic [1:0] {
    CKEV_CT_IDLE,
    CKEV_CT_STARTING,
    CKEV_CT_RUNNING,
    CKEV_CT_STOPPING
  } ckev_ct_state_t;

endpackage : ckev_pkg

/* ckev_sync.sv */
// three-stage synchroniser with agreement filter for oscillator status pins
// assumes inputs are asynchronous levels that settle for several cycles
`timescale 1ns/1ps
module ckev_sync
  import ckev_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // asynchronous levels and filtered result
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_level;

  // ==========================================================
  // filter: only the second and third stages are compared
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

endmodule : ckev_sync

/* ckev_flag.sv */
// one sticky event flag with software write access
// assumes set is a one-cycle pulse from logic on mclk
`timescale 1ns/1ps
module ckev_flag
  import ckev_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // hardware event and software write
  input wire logic set,
  input wire logic wr,
  input wire logic wbit,
  // flag state
  output logic flag
);

  logic next_flag;

  // a hardware event in the same cycle as a software write wins
  always_comb begin
    next_flag = flag;
    if (wr) begin
      next_flag = wbit;
    end
    if (set) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flag <= CKEV_RST_FLAG;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : ckev_flag

/* ckev_regs.sv */
// clock controller task, event and interrupt-enable registers
// assumes a single-cycle register port master on mclk and
// oscillator status levels arriving asynchronously from the analog side
//
// Overview of operation
// - stop task write stops calibration timer
// - crystal started sets its event flag
// - calibration done sets flag, software writes of zero clear
// - timer started event once running
// - timer stopped event once halted
// - enable-set bit0 enables crystal interrupt
// - bits 1,2 enable lf and done interrupts
// - bit3 enables timeout; timer expiry raises it
// - bits 4,5 enable timer interrupts; reset zero
// - enable-clear writes of one disable interrupts
// - start task write starts calibration timer
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module ckev_regs
  import ckev_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // oscillator status levels, asynchronous
  input wire logic hf_crystal_ready,
  input wire logic lf_clock_ready,
  input wire logic rc_cal_complete,
  // calibration timer state and interrupt
  output logic cal_timer_running,
  output logic irq
);

  // ==========================================================
  // status input synchronisation and edge detect
  logic [2:0] osc_level;
  logic [2:0] osc_level_d;
  logic [2:0] next_osc_level_d;
  logic [2:0] osc_rise;

  ckev_sync #(.W(3)) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .async_in({rc_cal_complete, lf_clock_ready, hf_crystal_ready}),
    .level(osc_level)
  );

  always_comb begin
    next_osc_level_d = osc_level;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      osc_level_d <= '0;
    end else begin
      osc_level_d <= next_osc_level_d;
    end
  end

  // each event fires once on the rising edge of its filtered level
  assign osc_rise = osc_level & ~osc_level_d;

  // ==========================================================
  // register decode
  logic wr_ct_start;
  logic wr_ct_stop;
  logic wr_int_set;
  logic wr_int_clr;

  assign wr_ct_start = reg_wr && (reg_addr == CKEV_OFF_CT_START) && reg_wdata[CKEV_BIT_TRIG];
  assign wr_ct_stop = reg_wr && (reg_addr == CKEV_OFF_CT_STOP) && reg_wdata[CKEV_BIT_TRIG];
  assign wr_int_set = reg_wr && (reg_addr == CKEV_OFF_INT_SET);
  assign wr_int_clr = reg_wr && (reg_addr == CKEV_OFF_INT_CLR);

  // ==========================================================
  // calibration timer
  ckev_ct_state_t ct_state;
  ckev_ct_state_t next_ct_state;
  logic [CKEV_CTW-1:0] ct_count;
  logic [CKEV_CTW-1:0] next_ct_count;
  logic ev_ctstart;
  logic ev_ctstop;
  logic ev_tmo;

  always_comb begin
    next_ct_state = ct_state;
    next_ct_count = ct_count;
    ev_ctstart = 1'b0;
    ev_ctstop = 1'b0;
    ev_tmo = 1'b0;
    case (ct_state)
      CKEV_CT_IDLE: begin
        if (wr_ct_start) begin
          next_ct_state = CKEV_CT_STARTING;
          next_ct_count = CKEV_CTW'(CKEV_CT_START_CYC - 1);
        end else if (wr_ct_stop) begin
          // already halted: still acknowledge so software sees readiness
          next_ct_state = CKEV_CT_STOPPING;
        end
      end
      CKEV_CT_STARTING: begin
        if (wr_ct_stop) begin
          next_ct_state = CKEV_CT_STOPPING;
        end else if (ct_count == '0) begin
          next_ct_state = CKEV_CT_RUNNING;
          next_ct_count = CKEV_CTW'(CKEV_CT_PERIOD_CYC - 1);
          ev_ctstart = 1'b1;
        end else begin
          next_ct_count = ct_count - 1'b1;
        end
      end
      CKEV_CT_RUNNING: begin
        if (wr_ct_stop) begin
          next_ct_state = CKEV_CT_STOPPING;
        end else if (wr_ct_start) begin
          // restart reloads the interval, timer stays running
          next_ct_count = CKEV_CTW'(CKEV_CT_PERIOD_CYC - 1);
          ev_ctstart = 1'b1;
        end else if (ct_count == '0) begin
          next_ct_state = CKEV_CT_IDLE;
          ev_tmo = 1'b1;
        end else begin
          next_ct_count = ct_count - 1'b1;
        end
      end
      CKEV_CT_STOPPING: begin
        next_ct_state = CKEV_CT_IDLE;
        next_ct_count = '0;
        ev_ctstop = 1'b1;
      end
      default: begin
        next_ct_state = CKEV_CT_IDLE;
        next_ct_count = '0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ct_state <= CKEV_CT_IDLE;
      ct_count <= '0;
    end else begin
      ct_state <= next_ct_state;
      ct_count <= next_ct_count;
    end
  end

  assign cal_timer_running = (ct_state == CKEV_CT_RUNNING);

  // ==========================================================
  // event flags
  logic [5:0] hw_set;
  logic [5:0] ev_flags;

  assign hw_set[CKEV_BIT_HF] = osc_rise[0];
  assign hw_set[CKEV_BIT_LF] = osc_rise[1];
  assign hw_set[CKEV_BIT_DONE] = osc_rise[2];
  assign hw_set[CKEV_BIT_TMO] = ev_tmo;
  assign hw_set[CKEV_BIT_CTSTART] = ev_ctstart;
  assign hw_set[CKEV_BIT_CTSTOP] = ev_ctstop;

  genvar gi;
  generate
    for (gi = 0; gi < CKEV_NEV; gi++) begin : g_flag
      ckev_flag u_flag (
        .mclk(mclk),
        .arst_n(arst_n),
        .set(hw_set[gi]),
        .wr(reg_wr && (reg_addr == CKEV_EV_OFF[gi])),
        .wbit(reg_wdata[0]),
        .flag(ev_flags[gi])
      );
    end
  endgenerate

  // ==========================================================
  // interrupt enables: set and clear views of one register
  logic [5:0] int_en;
  logic [5:0] next_int_en;

  always_comb begin
    next_int_en = int_en;
    if (wr_int_set) begin
      next_int_en = int_en | reg_wdata[5:0];
    end else if (wr_int_clr) begin
      next_int_en = int_en & ~reg_wdata[5:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      int_en <= CKEV_RST_INT_EN;
    end else begin
      int_en <= next_int_en;
    end
  end

  // level output, no edge: it drops only once the flag or enable is cleared
  assign irq = |(ev_flags & int_en);

  // ==========================================================
  // read path, data registered one cycle after the strobe
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = CKEV_RST_WORD;
    if (reg_rd) begin
      case (reg_addr)
        CKEV_OFF_EV_HF: next_rdata = {31'h0000_0000, ev_flags[CKEV_BIT_HF]};
        CKEV_OFF_EV_LF: next_rdata = {31'h0000_0000, ev_flags[CKEV_BIT_LF]};
        CKEV_OFF_EV_DONE: next_rdata = {31'h0000_0000, ev_flags[CKEV_BIT_DONE]};
        CKEV_OFF_EV_TMO: next_rdata = {31'h0000_0000, ev_flags[CKEV_BIT_TMO]};
        CKEV_OFF_EV_CTSTART: next_rdata = {31'h0000_0000, ev_flags[CKEV_BIT_CTSTART]};
        CKEV_OFF_EV_CTSTOP: next_rdata = {31'h0000_0000, ev_flags[CKEV_BIT_CTSTOP]};
        CKEV_OFF_INT_SET: next_rdata = {26'h000_0000, int_en};
        CKEV_OFF_INT_CLR: next_rdata = {26'h000_0000, int_en};
        // task registers and unmapped offsets read as zero
        default: next_rdata = CKEV_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= CKEV_RST_WORD;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_stop_task;
    wr_ct_stop && !wr_ct_start |-> ##2 (ct_state == CKEV_CT_IDLE) && ev_flags[CKEV_BIT_CTSTOP];
  endproperty
  a_stop_task: assert property (p_stop_task) else $error("stop task did not halt timer");

  property p_hf_event;
    osc_rise[0] |=> ev_flags[CKEV_BIT_HF];
  endproperty
  a_hf_event: assert property (p_hf_event) else $error("crystal event not flagged");

  property p_done_clear;
    reg_wr && (reg_addr == CKEV_OFF_EV_DONE) && !reg_wdata[0] && !osc_rise[2]
      |=> !ev_flags[CKEV_BIT_DONE];
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

  property p_started;
    (ct_state == CKEV_CT_IDLE) && wr_ct_start ##1 !wr_ct_stop [*2]
      |-> ##[1:3] ev_flags[CKEV_BIT_CTSTART];
  endproperty
  a_started: assert property (p_started) else $error("timer started event missing");

  property p_stopped_cause;
    $rose(ev_flags[CKEV_BIT_CTSTOP]) |->
      $past(ct_state == CKEV_CT_STOPPING) ||
      $past(reg_wr && (reg_addr == CKEV_OFF_EV_CTSTOP));
  endproperty
  a_stopped_cause: assert property (p_stopped_cause) else $error("stopped flag without cause");

  property p_en_set;
    wr_int_set |=> (int_en & $past(reg_wdata[5:0])) == $past(reg_wdata[5:0]);
  endproperty
  a_en_set: assert property (p_en_set) else $error("enable set not applied");

  property p_en_read;
    reg_rd && (reg_addr == CKEV_OFF_INT_SET) |=> reg_rdata == {26'h000_0000, $past(int_en)};
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable readback wrong");

  property p_timeout;
    (ct_state == CKEV_CT_RUNNING) && (ct_count == '0) && !wr_ct_stop && !wr_ct_start
      |=> ev_flags[CKEV_BIT_TMO] && (ct_state == CKEV_CT_IDLE);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not raised");

  property p_en_upper;
    reg_rd |=> reg_rdata[31:6] == 26'h000_0000;
  endproperty
  a_en_upper: assert property (p_en_upper) else $error("upper read bits not zero");

  property p_en_clr;
    wr_int_clr |=> (int_en & $past(reg_wdata[5:0])) == 6'h00;
  endproperty
  a_en_clr: assert property (p_en_clr) else $error("enable clear not applied");

  property p_start_task;
    (ct_state == CKEV_CT_IDLE) && wr_ct_start |=> ct_state == CKEV_CT_STARTING;
  endproperty
  a_start_task: assert property (p_start_task) else $error("start task ignored");

  property p_zero_set;
    wr_int_set && (reg_wdata[5:0] == 6'h00) |=> $stable(int_en);
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("zero write changed enables");

  property p_irq;
    wr_int_set && |(reg_wdata[5:0] & ev_flags) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_done_event;
    osc_rise[2] |=> ev_flags[CKEV_BIT_DONE];
  endproperty
  a_done_event: assert property (p_done_event) else $error("done event not flagged");

  property p_lf_event;
    osc_rise[1] |=> ev_flags[CKEV_BIT_LF];
  endproperty
  a_lf_event: assert property (p_lf_event) else $error("clock started event not flagged");

  property p_restart;
    (ct_state == CKEV_CT_RUNNING) && wr_ct_start
      |=> ev_flags[CKEV_BIT_CTSTART] && (ct_state == CKEV_CT_RUNNING);
  endproperty
  a_restart: assert property (p_restart) else $error("restart lost started event");

  property p_stop_running;
    (ct_state == CKEV_CT_RUNNING) && wr_ct_stop |=> !cal_timer_running;
  endproperty
  a_stop_running: assert property (p_stop_running) else $error("stop left timer running");

  property p_task_read;
    reg_rd && (reg_addr == CKEV_OFF_CT_STOP) |=> reg_rdata == CKEV_RST_WORD;
  endproperty
  a_task_read: assert property (p_task_read) else $error("task register not zero");

  property p_clr_all;
    wr_int_clr && (reg_wdata[5:0] == 6'h3f) |=> !irq;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("irq after clearing enables");

  property p_stop_idle;
    (ct_state == CKEV_CT_IDLE) && wr_ct_stop |=> ct_state == CKEV_CT_STOPPING;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("idle stop not acknowledged");

  c_timeout: cover property (ev_tmo);
  c_restart: cover property ((ct_state == CKEV_CT_RUNNING) && wr_ct_start);
  c_stop: cover property ((ct_state == CKEV_CT_RUNNING) && wr_ct_stop);
  c_irq: cover property ($rose(irq));
  c_hf: cover property (osc_rise[0] && int_en[CKEV_BIT_HF]);

endmodule : ckev_regs

/* ckev_regs_tb.sv */
// self-checking bench for the clock event register block
// assumes ckev_pkg is compiled first and the block asserts its own properties
`timescale 1ns/1ps
module ckev_regs_tb;
  import ckev_pkg::*;

  // ==========================================================
  // clock, reset and ports
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic hf_crystal_ready = 1'b0;
  logic lf_clock_ready = 1'b0;
  logic rc_cal_complete = 1'b0;
  logic cal_timer_running;
  logic irq;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 mclk = ~mclk;

  ckev_regs DUT (
    .mclk(mclk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .hf_crystal_ready(hf_crystal_ready),
    .lf_clock_ready(lf_clock_ready),
    .rc_cal_complete(rc_cal_complete),
    .cal_timer_running(cal_timer_running),
    .irq(irq)
  );

  // ==========================================================
  // helpers
  task automatic summarize();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // the full test is just over 4000 cycles; the timer interval dominates
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("[FAIL] %0t run did not finish", $time);
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp, $sformatf("read %h", a));
  endtask : chk_rd

  // irq is combinational from flops that update on the edge just passed
  task automatic chk_irq(input logic exp);
    #1;
    chk({31'h0, irq}, {31'h0, exp}, "irq");
  endtask : chk_irq

  task automatic wait_flag(input logic [11:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    for (int i = 0; i < 16 && d[0] !== 1'b1; i++) begin
      rd(a, d);
    end
    chk(d, 32'h0000_0001, $sformatf("flag at %h", a));
  endtask : wait_flag

  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < CKEV_NEV; i++) begin
      chk_rd(CKEV_EV_OFF[i], CKEV_RST_WORD);
    end
    chk_rd(CKEV_OFF_INT_SET, CKEV_RST_WORD);
    chk_rd(CKEV_OFF_INT_CLR, CKEV_RST_WORD);
    chk_rd(CKEV_OFF_CT_STOP, CKEV_RST_WORD);
    wr(12'h200, 32'hffff_ffff);
    chk_rd(12'h200, 32'h0000_0000);
    chk_irq(1'b0);
  endtask : t_reset

  task automatic t_enables();
    wr(CKEV_OFF_INT_SET, 32'h0000_0015);
    chk_rd(CKEV_OFF_INT_SET, 32'h0000_0015);
    wr(CKEV_OFF_INT_SET, 32'h0000_0000);
    chk_rd(CKEV_OFF_INT_SET, 32'h0000_0015);
    wr(CKEV_OFF_INT_SET, 32'h0000_002a);
    chk_rd(CKEV_OFF_INT_SET, 32'h0000_003f);
    wr(CKEV_OFF_INT_CLR, 32'h0000_0005);
    chk_rd(CKEV_OFF_INT_CLR, 32'h0000_003a);
    wr(CKEV_OFF_INT_CLR, 32'h0000_003f);
    chk_rd(CKEV_OFF_INT_SET, 32'h0000_0000);
  endtask : t_enables

  // one status pin rises with its interrupt masked, then unmasked and cleared
  task automatic t_pin(input int idx);
    logic [31:0] bitm;
    bitm = 32'h0000_0001 << idx;
    @(posedge mclk);
    case (idx)
      0: hf_crystal_ready <= 1'b1;
      1: lf_clock_ready <= 1'b1;
      default: rc_cal_complete <= 1'b1;
    endcase
    wait_flag(CKEV_EV_OFF[idx]);
    chk_irq(1'b0);
    wr(CKEV_OFF_INT_SET, bitm);
    chk_irq(1'b1);
    wr(CKEV_OFF_INT_CLR, bitm);
    chk_irq(1'b0);
    wr(CKEV_OFF_INT_SET, bitm);
    wr(CKEV_EV_OFF[idx], 32'h0000_0000);
    chk_irq(1'b0);
    chk_rd(CKEV_EV_OFF[idx], 32'h0000_0000);
    wr(CKEV_OFF_INT_CLR, bitm);
  endtask : t_pin

  task automatic t_start_stop();
    wr(CKEV_OFF_INT_SET, 32'h0000_0030);
    wr(CKEV_OFF_CT_START, 32'h0000_0001);
    wait_flag(CKEV_OFF_EV_CTSTART);
    chk({31'h0, cal_timer_running}, 32'h0000_0001, "running");
    chk_irq(1'b1);
    wr(CKEV_OFF_EV_CTSTART, 32'h0000_0000);
    chk_irq(1'b0);
    // a start while running reloads the interval and re-raises started
    wr(CKEV_OFF_CT_START, 32'h0000_0001);
    wait_flag(CKEV_OFF_EV_CTSTART);
    chk({31'h0, cal_timer_running}, 32'h0000_0001, "restarted");
    wr(CKEV_OFF_EV_CTSTART, 32'h0000_0000);
    wr(CKEV_OFF_CT_STOP, 32'h0000_0001);
    wait_flag(CKEV_OFF_EV_CTSTOP);
    chk({31'h0, cal_timer_running}, 32'h0000_0000, "stopped");
    chk_irq(1'b1);
    chk_rd(CKEV_OFF_CT_STOP, 32'h0000_0000);
    wr(CKEV_OFF_EV_CTSTOP, 32'h0000_0000);
    // a stop while idle is still acknowledged with the stopped event
    wr(CKEV_OFF_CT_STOP, 32'h0000_0001);
    wait_flag(CKEV_OFF_EV_CTSTOP);
    chk({31'h0, cal_timer_running}, 32'h0000_0000, "idle stop");
    wr(CKEV_OFF_EV_CTSTOP, 32'h0000_0000);
    wr(CKEV_OFF_INT_CLR, 32'h0000_0030);
  endtask : t_start_stop

  // expiry after the fixed interval raises timeout, not the stopped event
  task automatic t_timeout();
    int n;
    n = 0;
    wr(CKEV_OFF_INT_SET, 32'h0000_0008);
    wr(CKEV_OFF_CT_START, 32'h0000_0001);
    repeat (4) @(posedge mclk);
    #1;
    n = 4;
    while (cal_timer_running === 1'b1 && n < 5000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({31'h0, n >= CKEV_CT_PERIOD_CYC && n <= CKEV_CT_PERIOD_CYC + 8},
        32'h0000_0001, "interval");
    chk_rd(CKEV_OFF_EV_TMO, 32'h0000_0001);
    chk_irq(1'b1);
    chk_rd(CKEV_OFF_EV_CTSTOP, 32'h0000_0000);
  endtask : t_timeout

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_enables();
    for (int i = 0; i < 3; i++) begin
      t_pin(i);
    end
    t_start_stop();
    t_timeout();
    summarize();
  end

endmodule : ckev_regs_tb
